// File: hw/fls_pkg.sv
package fls_pkg;

  // ****************
  // clock and timing
  // ****************
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned CLK_MHZ      = CLK_HZ / 1_000_000;
  // shortest line period, i.e. the highest line rate allowed
  localparam int unsigned LINE_MIN_NS  = 1000;
  localparam int unsigned LINE_MIN_CYC = (LINE_MIN_NS * CLK_MHZ + 999) / 1000;

  // ****************
  // register offsets (byte addresses)
  // ****************
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_SEL    = 5'h04;
  localparam logic [4:0] OFS_HEIGHT = 5'h08;
  localparam logic [4:0] OFS_PERIOD = 5'h0C;
  localparam logic [4:0] OFS_STAT   = 5'h10;
  localparam logic [4:0] OFS_COUNT  = 5'h14;
  localparam logic [4:0] OFS_DROP   = 5'h18;

  // ****************
  // control fields
  // ****************
  localparam int unsigned CB_START   = 0;
  localparam int unsigned CB_STOP    = 1;
  localparam int unsigned CB_REPEAT  = 2;
  localparam int unsigned CB_FRM_ON  = 3;
  localparam int unsigned CB_LIN_ON  = 4;
  localparam int unsigned CB_FRM_LVL = 5;
  localparam int unsigned CB_LIN_FAL = 6;
  localparam int unsigned CB_CUT     = 7;
  localparam int unsigned CB_RATE_EN = 8;
  localparam int unsigned SEL_FRM_LO = 0;
  localparam int unsigned SEL_LIN_LO = 4;

  // ****************
  // reset values
  // ****************
  localparam logic [8:0]  CTRL_RST   = 9'h004;
  localparam logic [1:0]  FSEL_RST   = 2'h2;
  localparam logic [1:0]  LSEL_RST   = 2'h3;
  localparam logic [15:0] HEIGHT_RST = 16'h0003;
  localparam logic [23:0] PERIOD_RST = 24'h000064;

  typedef enum logic [1:0] {
    FLS_IDLE   = 2'b00,
    FLS_WFRAME = 2'b01,
    FLS_FRAME  = 2'b10
  } fls_state_type;

endpackage

// File: hw/fls_trig_cond.sv
`timescale 1ns/10ps
module fls_trig_cond (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic ce,
  // pin and conditioned view
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ****************
  // three-stage synchroniser
  // ****************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // change accepted only once stages two and three agree
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else if (ce) begin
      rise <= (s2_r == s3_r) && s3_r && !level;
      fall <= (s2_r == s3_r) && !s3_r && level;
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end

endmodule

// File: hw/fls_line_pacer.sv
`timescale 1ns/10ps
module fls_line_pacer (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // pacing
  input  wire logic        run,
  input  wire logic [23:0] period,
  output logic             tick
);

  logic [23:0] cnt_r;

  // internal line trigger, one pulse per period while running
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 24'h000000;
      tick  <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_r <= 24'h000000;
        tick  <= 1'b0;
      end else if (cnt_r >= period - 24'h000001) begin
        cnt_r <= 24'h000000;
        tick  <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 24'h000001;
        tick  <= 1'b0;
      end
    end
  end

  pacer_gap_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && tick) |=> !tick) else $error("line ticks closer than allowed");

endmodule

// File: hw/fls_top.sv
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// How it works
// - with triggers off, frames and lines start internally without stimulus.
// - with frame trigger on, a frame starts only on a supplied trigger.
// - free lines pace at the set line rate, else at maximum rate.
// - lines of a frame are acquired only after a qualifying frame trigger.
// - with line trigger on, each line starts on an external edge.
// - repeat-frames setting keeps acquiring frames until stop-acquire arrives.
// - line triggers arriving while waiting for frame trigger are discarded.
// - a frame closes after lines-per-frame lines, three by default.
// - frame trigger input selectable, edge or level activation.
// - line trigger input selectable independently, with its own edge activation.
// - level-high frame trigger with repeat-frames on runs frames back to back while high.
// - level drop without cut-last-frame still completes the closing frame.
// - level drop with cut-last-frame ends frame early, partial.
// - internally generated triggers never raise a wait indication.
// - separate wait indications for frame trigger and line trigger.
// - stop-acquire mid-frame closes it with the lines already taken.
module fls_top (
  // clock, reset, clock enable
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // register bus
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // trigger input lines
  input  wire logic [3:0]  trig_in,
  // sequencing outputs
  output logic             line_start,
  output logic             frame_start,
  output logic             frame_end,
  output logic             frame_partial,
  output logic             wait_frame,
  output logic             wait_line,
  output logic             acquiring
);

  fls_pkg::fls_state_type state_r;

  logic [8:0]  ctrl_r;
  logic [1:0]  fsel_r;
  logic [1:0]  lsel_r;
  logic [15:0] height_r;
  logic [23:0] period_r;
  logic        start_cmd_r;
  logic        stop_cmd_r;
  logic        acq_on_r;
  logic [15:0] lines_r;
  logic [15:0] frames_r;
  logic [15:0] partials_r;
  logic [15:0] drops_r;
  logic        wait_r;
  logic [31:0] rdata_r;
  logic        line_start_r;
  logic        frame_start_r;
  logic        frame_end_r;
  logic        frame_partial_r;
  logic        wait_frame_r;
  logic        wait_line_r;

  logic [3:0]  lvl;
  logic [3:0]  rise;
  logic [3:0]  fall;
  logic        tick;
  logic        wr_acc;
  logic        frm_on;
  logic        lin_on;
  logic        frm_lvl;
  logic        f_level;
  logic        frame_go;
  logic        line_evt;
  logic        cut_now;
  logic        last_line;
  logic [23:0] pace_per;
  logic [15:0] lines_inc;

  // zero lines per frame would never close a frame
  function automatic logic [15:0] eff_height(input logic [15:0] h);
    eff_height = (h == 16'h0000) ? 16'h0001 : h;
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // ****************
  // trigger conditioning
  // ****************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_in
      fls_trig_cond u_cond (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .ce      (ce),
        .pin_in  (trig_in[gi]),
        .level   (lvl[gi]),
        .rise    (rise[gi]),
        .fall    (fall[gi])
      );
    end
  endgenerate

  assign frm_on  = ctrl_r[fls_pkg::CB_FRM_ON];
  assign lin_on  = ctrl_r[fls_pkg::CB_LIN_ON];
  assign frm_lvl = ctrl_r[fls_pkg::CB_FRM_LVL];
  assign f_level = lvl[fsel_r];

  // qualifying frame trigger: internal, rising edge or high level
  assign frame_go = !frm_on || (frm_lvl ? f_level : rise[fsel_r]);

  // line event: external edge of selected polarity, else pacer tick
  assign line_evt = lin_on ? (ctrl_r[fls_pkg::CB_LIN_FAL] ? fall[lsel_r] : rise[lsel_r])
                           : tick;

  // level dropped mid-frame and closing frame is to be cut
  assign cut_now = frm_on && frm_lvl && !f_level && ctrl_r[fls_pkg::CB_CUT];

  assign lines_inc = lines_r + 16'h0001;
  assign last_line = (lines_inc == eff_height(height_r));

  // rate setting above the maximum rate is clamped to it
  assign pace_per = (ctrl_r[fls_pkg::CB_RATE_EN] && period_r > 24'(fls_pkg::LINE_MIN_CYC))
                    ? period_r : 24'(fls_pkg::LINE_MIN_CYC);

  fls_line_pacer u_pacer (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ce      (ce),
    .run     (state_r == fls_pkg::FLS_FRAME && !lin_on),
    .period  (pace_per),
    .tick    (tick)
  );

  // ****************
  // register bus slave
  // ****************
  assign wr_acc = avs_write && !wait_r;

  // one wait cycle, then a single-cycle answer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
    end else if (ce) begin
      if ((avs_read || avs_write) && wait_r) begin
        wait_r <= 1'b0;
        case (avs_address)
          fls_pkg::OFS_CTRL:   rdata_r <= {23'h000000, ctrl_r[8:2], 2'h0};
          fls_pkg::OFS_SEL:    rdata_r <= {26'h0000000, lsel_r, 2'h0, fsel_r};
          fls_pkg::OFS_HEIGHT: rdata_r <= {16'h0000, height_r};
          fls_pkg::OFS_PERIOD: rdata_r <= {8'h00, period_r};
          fls_pkg::OFS_STAT:   rdata_r <= {lines_r, 12'h000,
                                           state_r == fls_pkg::FLS_FRAME,
                                           wait_line_r, wait_frame_r, acq_on_r};
          fls_pkg::OFS_COUNT:  rdata_r <= {partials_r, frames_r};
          fls_pkg::OFS_DROP:   rdata_r <= {16'h0000, drops_r};
          default:             rdata_r <= 32'h00000000;
        endcase
      end else begin
        wait_r <= 1'b1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r   <= fls_pkg::CTRL_RST;
      fsel_r   <= fls_pkg::FSEL_RST;
      lsel_r   <= fls_pkg::LSEL_RST;
      height_r <= fls_pkg::HEIGHT_RST;
      period_r <= fls_pkg::PERIOD_RST;
    end else if (ce && wr_acc) begin
      case (avs_address)
        fls_pkg::OFS_CTRL:   ctrl_r <= {avs_writedata[8:2], 2'h0};
        fls_pkg::OFS_SEL: begin
          fsel_r <= avs_writedata[fls_pkg::SEL_FRM_LO +: 2];
          lsel_r <= avs_writedata[fls_pkg::SEL_LIN_LO +: 2];
        end
        fls_pkg::OFS_HEIGHT: height_r <= avs_writedata[15:0];
        fls_pkg::OFS_PERIOD: period_r <= avs_writedata[23:0];
        default:             ctrl_r <= ctrl_r;
      endcase
    end
  end

  // start and stop commands are self-clearing strobes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      start_cmd_r <= 1'b0;
      stop_cmd_r  <= 1'b0;
    end else if (ce) begin
      start_cmd_r <= wr_acc && avs_address == fls_pkg::OFS_CTRL && avs_writedata[fls_pkg::CB_START];
      stop_cmd_r  <= wr_acc && avs_address == fls_pkg::OFS_CTRL && avs_writedata[fls_pkg::CB_STOP];
    end
  end

  // ****************
  // acquisition enable
  // ****************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acq_on_r <= 1'b0;
    end else if (ce) begin
      if (stop_cmd_r) begin
        acq_on_r <= 1'b0;
      end else if (start_cmd_r) begin
        acq_on_r <= 1'b1;
      end else if (frame_end_r && !ctrl_r[fls_pkg::CB_REPEAT]) begin
        acq_on_r <= 1'b0;
      end
    end
  end

  // ****************
  // frame and line sequencer
  // ****************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r         <= fls_pkg::FLS_IDLE;
      lines_r         <= 16'h0000;
      line_start_r    <= 1'b0;
      frame_start_r   <= 1'b0;
      frame_end_r     <= 1'b0;
      frame_partial_r <= 1'b0;
    end else if (ce) begin
      line_start_r    <= 1'b0;
      frame_start_r   <= 1'b0;
      frame_end_r     <= 1'b0;
      frame_partial_r <= 1'b0;
      case (state_r)
        fls_pkg::FLS_IDLE: begin
          if (acq_on_r && !stop_cmd_r && !frame_end_r) begin
            state_r <= fls_pkg::FLS_WFRAME;
          end
        end
        fls_pkg::FLS_WFRAME: begin
          if (!acq_on_r || stop_cmd_r) begin
            state_r <= fls_pkg::FLS_IDLE;
          end else if (frame_go) begin
            state_r       <= fls_pkg::FLS_FRAME;
            lines_r       <= 16'h0000;
            frame_start_r <= 1'b1;
          end
        end
        fls_pkg::FLS_FRAME: begin
          if (stop_cmd_r || cut_now) begin
            state_r         <= fls_pkg::FLS_IDLE;
            frame_end_r     <= 1'b1;
            frame_partial_r <= 1'b1;
          end else if (line_evt) begin
            line_start_r <= 1'b1;
            lines_r      <= lines_inc;
            if (last_line) begin
              // full frame even if the level has dropped
              frame_end_r <= 1'b1;
              state_r     <= ctrl_r[fls_pkg::CB_REPEAT] ? fls_pkg::FLS_WFRAME
                                                        : fls_pkg::FLS_IDLE;
            end
          end
        end
        default: begin
          state_r <= fls_pkg::FLS_IDLE;
        end
      endcase
    end
  end

  // ****************
  // wait indications
  // ****************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wait_frame_r <= 1'b0;
      wait_line_r  <= 1'b0;
    end else if (ce) begin
      // only external triggers are waited for
      wait_frame_r <= state_r == fls_pkg::FLS_WFRAME && frm_on && !frame_go;
      wait_line_r  <= state_r == fls_pkg::FLS_FRAME && lin_on && !line_evt;
    end
  end

  // ****************
  // statistics
  // ****************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frames_r   <= 16'h0000;
      partials_r <= 16'h0000;
    end else if (ce && frame_end_r) begin
      frames_r <= sat_inc(frames_r);
      if (frame_partial_r) begin
        partials_r <= sat_inc(partials_r);
      end
    end
  end

  // discarded line triggers; a new one beats a clearing write
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      drops_r <= 16'h0000;
    end else if (ce) begin
      if (state_r == fls_pkg::FLS_WFRAME && lin_on && line_evt) begin
        drops_r <= (wr_acc && avs_address == fls_pkg::OFS_DROP) ? 16'h0001 : sat_inc(drops_r);
      end else if (wr_acc && avs_address == fls_pkg::OFS_DROP) begin
        drops_r <= 16'h0000;
      end
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign line_start      = line_start_r;
  assign frame_start     = frame_start_r;
  assign frame_end       = frame_end_r;
  assign frame_partial   = frame_partial_r;
  assign wait_frame      = wait_frame_r;
  assign wait_line       = wait_line_r;
  assign acquiring       = acq_on_r;

  // ****************
  // checks
  // ****************
  free_line_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && state_r == fls_pkg::FLS_FRAME && !lin_on && tick && !stop_cmd_r && !cut_now)
    |=> line_start_r) else $error("internal line tick lost");
  no_frame_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && state_r == fls_pkg::FLS_WFRAME && frm_on && !frame_go)
    |=> !frame_start_r) else $error("frame began without trigger");
  halt_line_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && state_r != fls_pkg::FLS_FRAME) |=> !line_start_r)
    else $error("line outside a frame");
  ext_line_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && state_r == fls_pkg::FLS_FRAME && lin_on && line_evt && !stop_cmd_r && !cut_now)
    |=> line_start_r) else $error("external line edge lost");
  repeat_run_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && frame_end_r && !frame_partial_r && ctrl_r[fls_pkg::CB_REPEAT] && acq_on_r)
    |-> state_r == fls_pkg::FLS_WFRAME) else $error("repeat frames stopped");
  drop_line_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && state_r == fls_pkg::FLS_WFRAME && !(wr_acc && avs_address == fls_pkg::OFS_DROP)
     && lin_on && line_evt && drops_r != 16'hFFFF)
    |=> drops_r == $past(drops_r) + 16'h0001) else $error("discarded trigger not counted");
  full_height_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (frame_end_r && !frame_partial_r) |-> lines_r == eff_height(height_r))
    else $error("frame closed at wrong line count");
  cut_frame_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && state_r == fls_pkg::FLS_FRAME && cut_now)
    |=> frame_end_r && frame_partial_r) else $error("closing frame not cut");
  // wait flags lag the config by one edge, so check what they become
  int_wait_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && !frm_on |=> !wait_frame_r) and (ce && !lin_on |=> !wait_line_r))
    else $error("wait shown for internal trigger");

endmodule

// File: testbench/fls_trig_src.sv
`timescale 1ns/10ps
module fls_trig_src (
  // clock
  input  wire logic       clk_sys,
  // pin selection
  input  wire logic [1:0] fsel,
  input  wire logic [1:0] lsel,
  // pins toward the device
  output logic      [3:0] trig_in
);
  logic frm = 1'h0;
  logic lin = 1'h0;

  // unselected pins idle low
  assign trig_in = ((4'h1 << fsel) & {4{frm}}) | ((4'h1 << lsel) & {4{lin}});

  task automatic set_frame(input logic v);
    @(posedge clk_sys);
    frm <= v;
  endtask

  task automatic pulse_frame();
    set_frame(1'h1);
    repeat (8) @(posedge clk_sys);
    frm <= 1'h0;
    repeat (16) @(posedge clk_sys);
  endtask

  // 24-cycle spacing keeps the rate below the 20-cycle maximum
  task automatic pulse_line();
    @(posedge clk_sys);
    lin <= 1'h1;
    repeat (8) @(posedge clk_sys);
    lin <= 1'h0;
    repeat (15) @(posedge clk_sys);
  endtask
endmodule

// File: testbench/test_fls_top.sv
`timescale 1ns/10ps
module test_fls_top;
  // ****************
  // bench signals
  // ****************
  logic        clk_sys = 1'h0;
  logic        arst_n;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  trig_in;
  logic        line_start;
  logic        frame_start;
  logic        frame_end;
  logic        frame_partial;
  logic        wait_frame;
  logic        wait_line;
  logic        acquiring;
  logic [1:0]  fsel = 2'h2;
  logic [1:0]  lsel = 2'h3;
  logic [31:0] rd;
  logic [4:0]  ra [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h1C, 5'h01};
  logic [31:0] re [6] = '{32'h4, 32'h32, 32'h3, 32'h64, 32'h0, 32'h0};
  int          n_errors = 0;
  int          checks = 0;
  int          n_ls = 0;
  int          n_fs = 0;
  int          n_fe = 0;
  int          n_fp = 0;
  int          n_wt = 0;
  int          cyc = 0;
  int          last_ls = 0;
  int          gap = 0;

  always #25 clk_sys = ~clk_sys;

  fls_top u_fls_top (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(1'h1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trig_in(trig_in), .line_start(line_start), .frame_start(frame_start), .frame_end(frame_end),
    .frame_partial(frame_partial), .wait_frame(wait_frame), .wait_line(wait_line), .acquiring(acquiring)
  );

  fls_trig_src u_fls_trig_src (.clk_sys(clk_sys), .fsel(fsel), .lsel(lsel), .trig_in(trig_in));

  // ****************
  // event counters
  // ****************
  always @(posedge clk_sys) begin
    cyc++;
    if (line_start === 1'h1) begin
      gap = cyc - last_ls;
      last_ls = cyc;
      n_ls++;
    end
    if (frame_start === 1'h1) n_fs++;
    if (frame_end === 1'h1) n_fe++;
    if (frame_partial === 1'h1) n_fp++;
    if (wait_frame !== 1'h0 || wait_line !== 1'h0) n_wt++;
  end

  // ****************
  // tasks
  // ****************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'h0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (i == 50) begin
      n_errors++;
      give_verdict();
    end
  endtask

  task automatic wait_fe(input int n);
    int i;
    for (i = 0; i < 2000; i++) begin
      if (n_fe >= n) break;
      @(posedge clk_sys);
    end
    if (i == 2000) begin
      n_errors++;
      give_verdict();
    end
  endtask

  // counters are cleared clear of the edge that updates them
  task automatic clr();
    @(posedge clk_sys);
    #1;
    n_ls = 0;
    n_fs = 0;
    n_fe = 0;
    n_fp = 0;
    n_wt = 0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    int k;
    arst_n = 1'h0;
    avs_address = 5'h00;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'h1;
    for (k = 0; k < 6; k++) begin
      bus(1'h0, ra[k], 32'h0);
      chk(rd, re[k]);
    end
    $display("test register reset values done");

    bus(1'h1, 5'h0C, 32'h1E);
    for (k = 0; k < 2; k++) begin
      clr();
      bus(1'h1, 5'h00, k ? 32'h1 : 32'h101);
      wait_fe(1);
      idle(5);
      chk(n_ls, 32'h3);
      chk(gap, k ? 32'h14 : 32'h1E);
      chk(n_fs, 32'h1);
      chk(n_wt, 32'h0);
      chk(acquiring, 32'h0);
    end
    $display("test free run done");

    fsel <= 2'h0;
    lsel <= 2'h1;
    bus(1'h1, 5'h04, 32'h10);
    clr();
    bus(1'h1, 5'h00, 32'h1D);
    idle(10);
    chk(wait_frame, 32'h1);
    u_fls_trig_src.pulse_line();
    chk(n_ls, 32'h0);
    bus(1'h0, 5'h18, 32'h0);
    chk(rd, 32'h1);
    u_fls_trig_src.pulse_frame();
    chk(n_fs, 32'h1);
    chk(wait_line, 32'h1);
    repeat (3) u_fls_trig_src.pulse_line();
    idle(30);
    chk(n_ls, 32'h3);
    chk(n_fe, 32'h1);
    chk(n_fs, 32'h1);
    chk(wait_frame, 32'h1);
    u_fls_trig_src.pulse_frame();
    u_fls_trig_src.pulse_line();
    bus(1'h1, 5'h00, 32'h2);
    wait_fe(2);
    chk(n_fp, 32'h1);
    chk(n_ls, 32'h4);
    bus(1'h0, 5'h14, 32'h0);
    chk(rd[31:16], 32'h1);
    $display("test edge triggers done");

    clr();
    bus(1'h1, 5'h00, 32'h3D);
    u_fls_trig_src.set_frame(1'h1);
    idle(10);
    repeat (3) u_fls_trig_src.pulse_line();
    chk(n_fs, 32'h2);
    u_fls_trig_src.pulse_line();
    u_fls_trig_src.set_frame(1'h0);
    repeat (2) u_fls_trig_src.pulse_line();
    idle(40);
    chk(n_fe, 32'h2);
    chk(n_fp, 32'h0);
    chk(n_fs, 32'h2);
    bus(1'h1, 5'h00, 32'h2);
    $display("test level trigger done");

    clr();
    bus(1'h1, 5'h00, 32'hBD);
    u_fls_trig_src.set_frame(1'h1);
    idle(10);
    u_fls_trig_src.pulse_line();
    u_fls_trig_src.set_frame(1'h0);
    idle(20);
    chk(n_fe, 32'h1);
    chk(n_fp, 32'h1);
    chk(n_ls, 32'h1);
    bus(1'h1, 5'h00, 32'h2);
    bus(1'h0, 5'h10, 32'h0);
    chk(rd[0], 32'h0);
    $display("test cut closing frame done");

    clr();
    bus(1'h1, 5'h08, 32'h2);
    bus(1'h1, 5'h00, 32'h55);
    repeat (2) u_fls_trig_src.pulse_line();
    chk(n_ls, 32'h2);
    chk(n_fe, 32'h1);
    chk(n_fp, 32'h0);
    chk(wait_line, 32'h1);
    bus(1'h1, 5'h00, 32'h2);
    idle(4);
    chk(n_fs, 32'h2);
    chk(n_fe, 32'h2);
    chk(n_fp, 32'h1);
    chk(wait_frame, 32'h0);
    $display("test falling line edge done");
    give_verdict();
  end
endmodule
